/* oag_pkg.sv */
// Package for the operand address generation block: modes, widths, constants.
// Assumes a 16-bit core with sixteen working registers and byte-addressed data space.
// Notes on behaviour
// - Two independent address units, X and Y, each yield an address per instruction.
// - Y unit serves only word reads of multiply-accumulate class instructions.
// - Addressing types offered: linear, modulo and bit-reversed.
// - Linear and modulo for data and program space; bit-reversed data only.
// - File register field is 13 bits, reaching the lowest 8192 bytes.
// - Working register zero is implied; result goes to file register or it.
// - File-register multiply writes a working register or a pair, never memory.
// - File-register move may reach the whole data space.
// - First source of three-operand instructions is a base register, register direct.
// - Second source: register, memory or 5-bit literal; result to register or memory.
// - Modes: direct, indirect, post-modified, pre-modified, 5 or 10 bit literal.
// - File register direct takes its address from the instruction field.
// - Register direct yields register contents and makes no memory access.
// - Register indirect uses the pointer as address and leaves it unchanged.
// - Post-modified uses the old pointer, then steps it by a constant.
// - Pre-modified steps the pointer by a signed constant, then uses it.
// - Register offset address is pointer plus base operand register.
// - Literal offset address is pointer plus instruction literal.
package oag_pkg;
  localparam int DATA_W = 16;
  localparam int FILE_ADDR_W = 13;
  localparam int NEAR_BYTES = 8192;
  localparam int FULL_ADDR_W = 16;
  localparam int SLIT_W = 5;
  localparam int LLIT_W = 10;
  localparam int REG_SEL_W = 4;
  localparam logic [REG_SEL_W-1:0] DEFAULT_WORKING_REGISTER_ZERO_SEL = 4'h0;
  localparam logic [REG_SEL_W-1:0] NO_REG_SEL = 4'hf;
  localparam logic [DATA_W-1:0] EA_RESET = 16'h0000;

  typedef enum logic [3:0] {
    OAG_FILE_DIRECT = 4'b0000,
    OAG_REG_DIRECT = 4'b0001,
    OAG_IND = 4'b0010,
    OAG_IND_POST = 4'b0011,
    OAG_IND_PRE = 4'b0100,
    OAG_IND_REG_OFS = 4'b0101,
    OAG_IND_LIT_OFS = 4'b0110,
    OAG_LIT5 = 4'b0111,
    OAG_LIT10 = 4'b1000
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_LINEAR = 2'b00,
    OAG_MODULO = 2'b01,
    OAG_BITREV = 2'b10
  } oag_atype_t;

  typedef enum logic [1:0] {
    OAG_DEST_FILE = 2'b00,
    OAG_DEST_DEFAULT_WORKING_REGISTER = 2'b01,
    OAG_DEST_WPAIR = 2'b10,
    OAG_DEST_MEM = 2'b11
  } oag_dest_t;
endpackage

/* oag_unit.sv */
// One address generator unit: effective address and pointer update per mode.
// Assumes register values arrive on the same clock; output is combinational.
`timescale 1ns/1ps
`default_nettype none
module oag_unit
  import oag_pkg::*;
(
  input wire oag_pkg::oag_mode_t mode,
  input wire logic [oag_pkg::DATA_W-1:0] ptr_val,
  input wire logic [oag_pkg::DATA_W-1:0] base_val,
  input wire logic [oag_pkg::DATA_W-1:0] step,
  input wire logic [oag_pkg::LLIT_W-1:0] lit,
  input wire logic [oag_pkg::DATA_W-1:0] ind_ofs,
  output logic [oag_pkg::DATA_W-1:0] ea,
  output logic [oag_pkg::DATA_W-1:0] ptr_new,
  output logic ptr_wr,
  output logic mem_acc
);
  always_comb
  begin
    ea = EA_RESET;
    ptr_new = ptr_val;
    ptr_wr = 1'b0;
    mem_acc = 1'b0;
    case (mode)
      OAG_IND:
      begin
        ea = ptr_val;
        mem_acc = 1'b1;
      end
      OAG_IND_POST:
      begin
        ea = ptr_val;
        ptr_new = ptr_val + step;
        ptr_wr = 1'b1;
        mem_acc = 1'b1;
      end
      OAG_IND_PRE:
      begin
        ea = ptr_val + step;
        ptr_new = ptr_val + step;
        ptr_wr = 1'b1;
        mem_acc = 1'b1;
      end
      OAG_IND_REG_OFS:
      begin
        ea = ptr_val + base_val;
        mem_acc = 1'b1;
      end
      OAG_IND_LIT_OFS:
      begin
        ea = ptr_val + ind_ofs;
        mem_acc = 1'b1;
      end
      default:
      begin
        ea = EA_RESET;
      end
    endcase
  end
endmodule
`default_nettype wire

/* oag_wsel.sv */
// Working register selector: reads one of sixteen working registers.
// Assumes the register file presents all sixteen values flat.
`timescale 1ns/1ps
`default_nettype none
module oag_wsel
  import oag_pkg::*;
(
  input wire logic [16*oag_pkg::DATA_W-1:0] wregs,
  input wire logic [oag_pkg::REG_SEL_W-1:0] sel,
  output logic [oag_pkg::DATA_W-1:0] val
);
  assign val = wregs[sel*DATA_W +: DATA_W];
endmodule
`default_nettype wire

/* oag_top.sv */
// Operand address generation: X and Y units, file-register and literal paths.
// Assumes the decoder holds its request one cycle; register file writes follow ptr outputs.
`timescale 1ns/1ps
`default_nettype none
module oag_top
  import oag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic [16*oag_pkg::DATA_W-1:0] wregs,
  input wire oag_pkg::oag_mode_t x_mode,
  input wire oag_pkg::oag_atype_t x_atype,
  input wire logic x_prog_space,
  input wire logic [oag_pkg::REG_SEL_W-1:0] x_ptr_sel,
  input wire logic [oag_pkg::REG_SEL_W-1:0] base_sel,
  input wire logic [oag_pkg::DATA_W-1:0] x_step,
  input wire logic [oag_pkg::LLIT_W-1:0] lit,
  input wire logic [oag_pkg::DATA_W-1:0] lit_ofs,
  input wire logic [oag_pkg::FILE_ADDR_W-1:0] file_addr,
  input wire logic [oag_pkg::DATA_W-1:0] move_addr,
  input wire logic file_op,
  input wire logic move_op,
  input wire logic multiply_operation,
  input wire logic mul_pair,
  input wire logic dest_to_default_working_register,
  input wire logic dest_to_mem,
  input wire logic y_req,
  input wire logic y_mac,
  input wire logic y_write,
  input wire logic y_byte,
  input wire oag_pkg::oag_mode_t y_mode,
  input wire logic [oag_pkg::REG_SEL_W-1:0] y_ptr_sel,
  input wire logic [oag_pkg::DATA_W-1:0] y_step,
  output logic x_valid_q,
  output logic [oag_pkg::DATA_W-1:0] x_ea_q,
  output logic x_mem_q,
  output logic [oag_pkg::DATA_W-1:0] x_operand_q,
  output logic x_ptr_wr_q,
  output logic [oag_pkg::REG_SEL_W-1:0] x_ptr_idx_q,
  output logic [oag_pkg::DATA_W-1:0] x_ptr_new_q,
  output logic [oag_pkg::DATA_W-1:0] base_operand_q,
  output oag_pkg::oag_dest_t dest_q,
  output oag_pkg::oag_atype_t x_atype_q,
  output logic x_prog_q,
  output logic y_valid_q,
  output logic y_reject_q,
  output logic [oag_pkg::DATA_W-1:0] y_ea_q,
  output logic y_ptr_wr_q,
  output logic [oag_pkg::REG_SEL_W-1:0] y_ptr_idx_q,
  output logic [oag_pkg::DATA_W-1:0] y_ptr_new_q
);
  logic [DATA_W-1:0] x_ptr_val;
  logic [DATA_W-1:0] y_ptr_val;
  logic [DATA_W-1:0] base_val;
  logic [DATA_W-1:0] default_working_register_zero;
  logic [DATA_W-1:0] x_ea;
  logic [DATA_W-1:0] x_ptr_new;
  logic x_ptr_wr;
  logic x_mem;
  logic [DATA_W-1:0] y_ea;
  logic [DATA_W-1:0] y_ptr_new;
  logic y_ptr_wr;
  logic y_mem;
  logic y_ok;
  logic [DATA_W-1:0] file_ea;
  logic [DATA_W-1:0] x_ea_d;
  logic [DATA_W-1:0] x_operand_d;
  logic x_mem_d;
  oag_dest_t dest_d;
  oag_atype_t x_atype_d;

  // The file field and literals must fit one data word, and the field must span the near region
  if (FILE_ADDR_W > DATA_W || LLIT_W > DATA_W || SLIT_W > LLIT_W
    || NEAR_BYTES != (1 << FILE_ADDR_W))
  begin : g_width_check
    $error("address or literal width does not fit the data word");
  end

  oag_wsel u_xsel (.wregs(wregs), .sel(x_ptr_sel), .val(x_ptr_val));
  oag_wsel u_ysel (.wregs(wregs), .sel(y_ptr_sel), .val(y_ptr_val));
  oag_wsel u_bsel (.wregs(wregs), .sel(base_sel), .val(base_val));
  oag_wsel u_zsel (.wregs(wregs), .sel(DEFAULT_WORKING_REGISTER_ZERO_SEL), .val(default_working_register_zero));

  // Two separate units so X and Y addresses form in the same instruction
  oag_unit u_x (
    .mode(x_mode),
    .ptr_val(x_ptr_val),
    .base_val(base_val),
    .step(x_step),
    .lit(lit),
    .ind_ofs(lit_ofs),
    .ea(x_ea),
    .ptr_new(x_ptr_new),
    .ptr_wr(x_ptr_wr),
    .mem_acc(x_mem)
  );

  oag_unit u_y (
    .mode(y_mode),
    .ptr_val(y_ptr_val),
    .base_val(base_val),
    .step(y_step),
    .lit(lit),
    .ind_ofs(lit_ofs),
    .ea(y_ea),
    .ptr_new(y_ptr_new),
    .ptr_wr(y_ptr_wr),
    .mem_acc(y_mem)
  );

  // Y only serves MAC-class word reads; anything else is turned away
  assign y_ok = y_req && y_mac && !y_write && !y_byte;

  // Near region for most file ops; move reaches the full space
  assign file_ea = move_op ? move_addr : {{(DATA_W-FILE_ADDR_W){1'b0}}, file_addr};

  always_comb
  begin
    x_ea_d = x_ea;
    x_mem_d = x_mem;
    x_operand_d = EA_RESET;
    case (x_mode)
      OAG_REG_DIRECT: x_operand_d = x_ptr_val;
      OAG_LIT5: x_operand_d = {{(DATA_W-SLIT_W){1'b0}}, lit[SLIT_W-1:0]};
      OAG_LIT10: x_operand_d = {{(DATA_W-LLIT_W){1'b0}}, lit};
      default: x_operand_d = EA_RESET;
    endcase
    // File instructions pair with register zero whatever the mode field says
    if (file_op || x_mode == OAG_FILE_DIRECT)
    begin
      x_ea_d = file_ea;
      x_mem_d = 1'b1;
      x_operand_d = default_working_register_zero;
    end
  end

  always_comb
  begin
    dest_d = dest_to_mem ? OAG_DEST_MEM : OAG_DEST_DEFAULT_WORKING_REGISTER;
    if (file_op)
    begin
      if (multiply_operation)
        dest_d = mul_pair ? OAG_DEST_WPAIR : OAG_DEST_DEFAULT_WORKING_REGISTER;
      else
        dest_d = dest_to_default_working_register ? OAG_DEST_DEFAULT_WORKING_REGISTER : OAG_DEST_FILE;
    end
  end

  // Bit-reversed type has no meaning in program space; fall back to linear
  always_comb
  begin
    x_atype_d = x_atype;
    if (x_prog_space && x_atype == OAG_BITREV)
      x_atype_d = OAG_LINEAR;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      x_valid_q <= 1'b0;
      x_ea_q <= EA_RESET;
      x_mem_q <= 1'b0;
      x_operand_q <= EA_RESET;
      base_operand_q <= EA_RESET;
      dest_q <= OAG_DEST_FILE;
      x_atype_q <= OAG_LINEAR;
      x_prog_q <= 1'b0;
    end
    else
    begin
      x_valid_q <= req;
      if (req)
      begin
        x_ea_q <= x_ea_d;
        x_mem_q <= x_mem_d;
        x_operand_q <= x_operand_d;
        base_operand_q <= base_val;
        dest_q <= dest_d;
        x_atype_q <= x_atype_d;
        x_prog_q <= x_prog_space;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      x_ptr_wr_q <= 1'b0;
      x_ptr_idx_q <= NO_REG_SEL;
      x_ptr_new_q <= EA_RESET;
    end
    else
    begin
      x_ptr_wr_q <= req && !file_op && x_ptr_wr;
      x_ptr_idx_q <= x_ptr_sel;
      x_ptr_new_q <= x_ptr_new;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      y_valid_q <= 1'b0;
      y_reject_q <= 1'b0;
      y_ea_q <= EA_RESET;
      y_ptr_wr_q <= 1'b0;
      y_ptr_idx_q <= NO_REG_SEL;
      y_ptr_new_q <= EA_RESET;
    end
    else
    begin
      y_valid_q <= y_ok && y_mem;
      y_reject_q <= y_req && !y_ok;
      if (y_ok)
        y_ea_q <= y_ea;
      y_ptr_wr_q <= y_ok && y_ptr_wr;
      y_ptr_idx_q <= y_ptr_sel;
      y_ptr_new_q <= y_ptr_new;
    end
  end

  chk_post_uses_old: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND_POST) |=> (x_ea_q == $past(x_ptr_val)
    && x_ptr_new_q == $past(x_ptr_val) + $past(x_step) && x_ptr_wr_q))
    else $error("post-modify address or update wrong");

  chk_pre_uses_new: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND_PRE)
    |=> (x_ea_q == $past(x_ptr_val) + $past(x_step) && x_ea_q == x_ptr_new_q && x_ptr_wr_q))
    else $error("pre-modify address not the updated pointer");

  chk_ind_no_write: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND) |=> (x_ea_q == $past(x_ptr_val) && !x_ptr_wr_q))
    else $error("indirect changed pointer or address wrong");

  chk_regofs_sum: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND_REG_OFS)
    |=> (x_ea_q == $past(x_ptr_val) + $past(base_val)))
    else $error("register offset sum wrong");

  chk_litofs_sum: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND_LIT_OFS)
    |=> (x_ea_q == $past(x_ptr_val) + $past(lit_ofs)))
    else $error("literal offset sum wrong");

  chk_ofs_no_wb: assert property (@(posedge clk) disable iff (srst)
    ((x_mode == OAG_IND_REG_OFS || x_mode == OAG_IND_LIT_OFS) && req) |=> !x_ptr_wr_q)
    else $error("offset mode wrote the pointer");

  chk_near_region: assert property (@(posedge clk) disable iff (srst)
    (req && file_op && !move_op) |=> (x_ea_q < NEAR_BYTES))
    else $error("file address left near region");

  chk_mul_dest: assert property (@(posedge clk) disable iff (srst)
    (req && file_op && multiply_operation) |=> (dest_q != OAG_DEST_FILE))
    else $error("multiply wrote back to file register");

  chk_y_only_mac: assert property (@(posedge clk) disable iff (srst)
    (y_req && (y_write || y_byte || !y_mac)) |=> (y_reject_q && !y_valid_q && !y_ptr_wr_q))
    else $error("Y unit served a non MAC word read");

  chk_regdir_value: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_REG_DIRECT)
    |=> (x_operand_q == $past(x_ptr_val) && !x_mem_q))
    else $error("register direct wrong or touched memory");

  chk_file_wzero: assert property (@(posedge clk) disable iff (srst)
    (req && file_op) |=> (x_operand_q == $past(default_working_register_zero) && x_mem_q))
    else $error("file op lost the implied working register");

  chk_file_field: assert property (@(posedge clk) disable iff (srst)
    (req && (file_op || x_mode == OAG_FILE_DIRECT) && !move_op)
    |=> (x_ea_q[FILE_ADDR_W-1:0] == $past(file_addr) && x_mem_q))
    else $error("file register address not taken from the field");

  chk_move_full: assert property (@(posedge clk) disable iff (srst)
    (req && file_op && move_op) |=> (x_ea_q == $past(move_addr)))
    else $error("move did not reach its full address");

  chk_lit5_zext: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_LIT5)
    |=> (x_operand_q[SLIT_W-1:0] == $past(lit[SLIT_W-1:0])
    && x_operand_q[DATA_W-1:SLIT_W] == '0 && !x_mem_q))
    else $error("short literal operand wrong");

  chk_lit10_zext: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_LIT10)
    |=> (x_operand_q == {{(DATA_W-LLIT_W){1'b0}}, $past(lit)} && !x_mem_q))
    else $error("long literal operand wrong");

  chk_y_mac_served: assert property (@(posedge clk) disable iff (srst)
    (y_req && y_mac && !y_write && !y_byte && (y_mode == OAG_IND || y_mode == OAG_IND_POST))
    |=> (y_valid_q && !y_reject_q && y_ea_q == $past(y_ptr_val)))
    else $error("Y unit refused or misaddressed a MAC word read");

  chk_x_y_together: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op && x_mode == OAG_IND && y_req && y_mac && !y_write && !y_byte
    && y_mode == OAG_IND_POST) |=> (x_valid_q && y_valid_q && x_ea_q == $past(x_ptr_val)
    && y_ea_q == $past(y_ptr_val)))
    else $error("X and Y addresses not formed together");

  chk_bitrev_data: assert property (@(posedge clk) disable iff (srst)
    (req && x_prog_space) |=> (x_atype_q != OAG_BITREV && x_prog_q))
    else $error("bit-reversed type passed for program space");

  chk_dest_nonfile: assert property (@(posedge clk) disable iff (srst)
    (req && !file_op) |=> (dest_q == OAG_DEST_DEFAULT_WORKING_REGISTER || dest_q == OAG_DEST_MEM))
    else $error("non-file result sent to file register or pair");
endmodule
`default_nettype wire

/* oag_regfile_model.sv */
// Working register file model for the far side of the address generator.
// Assumes pointer write-backs arrive as one-cycle pulses from the design.
`timescale 1ns/1ps
`default_nettype none
module oag_regfile_model
  import oag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ld_en,
  input wire logic [3:0] ld_idx,
  input wire logic [15:0] ld_val,
  input wire logic x_wr,
  input wire logic [3:0] x_idx,
  input wire logic [15:0] x_val,
  input wire logic y_wr,
  input wire logic [3:0] y_idx,
  input wire logic [15:0] y_val,
  output logic [16*oag_pkg::DATA_W-1:0] wregs
);
  // Write-back lands one edge after the design reports it, as a real file would
  always_ff @(posedge clk)
  begin
    if (srst)
      wregs <= '0;
    else
    begin
      if (ld_en)
        wregs[16*ld_idx +: 16] <= ld_val;
      if (x_wr)
        wregs[16*x_idx +: 16] <= x_val;
      if (y_wr)
        wregs[16*y_idx +: 16] <= y_val;
    end
  end
endmodule
`default_nettype wire

/* tb_operand_address_generation.sv */
// Self-checking bench for the operand address generator top.
// Assumes the register file model above feeds the working registers.
`timescale 1ns/1ps
`default_nettype none
module tb_operand_address_generation;
  import oag_pkg::*;
  logic clk, srst, req, x_prog_space, file_op, move_op, mul, mul_pair, to_w, to_mem;
  logic y_req, y_mac, y_write, y_byte, ld_en;
  logic [255:0] wregs;
  oag_mode_t x_mode, y_mode;
  oag_atype_t x_atype, x_atype_q;
  oag_dest_t dest_q;
  logic [3:0] x_ptr_sel, base_sel, y_ptr_sel, ld_idx, x_ptr_idx_q, y_ptr_idx_q;
  logic [15:0] x_step, lit_ofs, move_addr, y_step, ld_val, x_ea_q, x_operand_q, x_ptr_new_q;
  logic [15:0] base_operand_q, y_ea_q, y_ptr_new_q;
  logic [9:0] lit;
  logic [12:0] file_addr;
  logic x_valid_q, x_mem_q, x_ptr_wr_q, x_prog_q, y_valid_q, y_reject_q, y_ptr_wr_q;
  int num_errors, num_checks, cycles;

  oag_top uut (.clk(clk), .srst(srst), .req(req), .wregs(wregs), .x_mode(x_mode),
    .x_atype(x_atype), .x_prog_space(x_prog_space), .x_ptr_sel(x_ptr_sel),
    .base_sel(base_sel), .x_step(x_step), .lit(lit), .lit_ofs(lit_ofs),
    .file_addr(file_addr), .move_addr(move_addr), .file_op(file_op), .move_op(move_op),
    .multiply_operation(mul), .mul_pair(mul_pair), .dest_to_default_working_register(to_w),
    .dest_to_mem(to_mem), .y_req(y_req), .y_mac(y_mac), .y_write(y_write),
    .y_byte(y_byte), .y_mode(y_mode), .y_ptr_sel(y_ptr_sel), .y_step(y_step),
    .x_valid_q(x_valid_q), .x_ea_q(x_ea_q), .x_mem_q(x_mem_q), .x_operand_q(x_operand_q),
    .x_ptr_wr_q(x_ptr_wr_q), .x_ptr_idx_q(x_ptr_idx_q), .x_ptr_new_q(x_ptr_new_q),
    .base_operand_q(base_operand_q), .dest_q(dest_q), .x_atype_q(x_atype_q),
    .x_prog_q(x_prog_q), .y_valid_q(y_valid_q), .y_reject_q(y_reject_q), .y_ea_q(y_ea_q),
    .y_ptr_wr_q(y_ptr_wr_q), .y_ptr_idx_q(y_ptr_idx_q), .y_ptr_new_q(y_ptr_new_q));

  oag_regfile_model far (.clk(clk), .srst(srst), .ld_en(ld_en), .ld_idx(ld_idx),
    .ld_val(ld_val), .x_wr(x_ptr_wr_q), .x_idx(x_ptr_idx_q), .x_val(x_ptr_new_q),
    .y_wr(y_ptr_wr_q), .y_idx(y_ptr_idx_q), .y_val(y_ptr_new_q), .wregs(wregs));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Raises the requests for exactly one edge; outputs are settled on return
  task automatic go(input logic xr, input logic yr);
    @(posedge clk);
    #1;
    req = xr;
    y_req = yr;
    @(posedge clk);
    #1;
    req = 1'b0;
    y_req = 1'b0;
  endtask

  task automatic ld(input logic [3:0] i, input logic [15:0] v);
    @(posedge clk);
    #1;
    ld_idx = i;
    ld_val = v;
    ld_en = 1'b1;
    @(posedge clk);
    #1;
    ld_en = 1'b0;
  endtask

  task automatic t_offsets();
    x_ptr_sel = 4'h3;
    base_sel = 4'h5;
    x_mode = OAG_IND;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h0100, "ind ea");
    chk(x_ptr_wr_q, 1'b0, "ind wr");
    chk(x_valid_q & x_mem_q, 1'b1, "ind valid");
    chk(base_operand_q, 16'h0020, "base");
    x_mode = OAG_IND_REG_OFS;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h0120, "reg ofs");
    chk(x_ptr_wr_q, 1'b0, "reg ofs wr");
    x_mode = OAG_IND_LIT_OFS;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h00fe, "lit ofs");
    chk(x_ptr_wr_q, 1'b0, "lit ofs wr");
  endtask

  task automatic t_modified();
    x_mode = OAG_IND_POST;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h0100, "post ea");
    chk({x_ptr_wr_q, x_ptr_idx_q}, 5'h13, "post wr");
    chk(x_ptr_new_q, 16'h0102, "post new");
    x_mode = OAG_IND_PRE;
    x_step = 16'hfffc;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h00fe, "pre ea");
    chk(x_ptr_new_q, 16'h00fe, "pre new");
  endtask

  task automatic t_direct();
    x_mode = OAG_REG_DIRECT;
    to_mem = 1'b1;
    go(1'b1, 1'b0);
    chk(x_operand_q, 16'h00fe, "direct");
    chk(x_mem_q, 1'b0, "direct mem");
    chk(dest_q, OAG_DEST_MEM, "dest mem");
    x_mode = OAG_LIT5;
    to_mem = 1'b0;
    go(1'b1, 1'b0);
    chk(x_operand_q, 16'h001f, "lit5");
    chk(dest_q, OAG_DEST_DEFAULT_WORKING_REGISTER, "dest w");
    x_mode = OAG_LIT10;
    go(1'b1, 1'b0);
    chk(x_operand_q, 16'h03ff, "lit10");
  endtask

  task automatic t_file();
    x_mode = OAG_IND_POST;
    file_op = 1'b1;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h1fff, "file ea");
    chk(x_operand_q, 16'h0777, "implied w0");
    chk({x_ptr_wr_q, dest_q}, OAG_DEST_FILE, "file dest");
    to_w = 1'b1;
    go(1'b1, 1'b0);
    chk(dest_q, OAG_DEST_DEFAULT_WORKING_REGISTER, "file to w");
    to_w = 1'b0;
    mul = 1'b1;
    go(1'b1, 1'b0);
    chk(dest_q, OAG_DEST_DEFAULT_WORKING_REGISTER, "mul");
    mul_pair = 1'b1;
    go(1'b1, 1'b0);
    chk(dest_q, OAG_DEST_WPAIR, "mul pair");
    mul = 1'b0;
    move_op = 1'b1;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'habcd, "move");
    file_op = 1'b0;
    move_op = 1'b0;
    x_mode = OAG_FILE_DIRECT;
    go(1'b1, 1'b0);
    chk(x_ea_q, 16'h1fff, "file mode ea");
    chk(x_operand_q, 16'h0777, "file mode w0");
    chk(x_mem_q, 1'b1, "file mode mem");
  endtask

  task automatic t_y();
    logic [2:0] q;
    x_mode = OAG_IND;
    y_mode = OAG_IND_POST;
    for (int i = 0; i < 8; i++)
    begin
      q = 3'(i);
      {y_mac, y_write, y_byte} = q;
      go(1'b1, 1'b1);
      chk({y_valid_q, y_reject_q}, (q == 3'b100) ? 2'b10 : 2'b01, "y accept");
      chk(y_ptr_wr_q, q == 3'b100, "y wr");
      chk(x_valid_q, 1'b1, "x beside y");
      if (q == 3'b100)
        chk(y_ptr_new_q, 16'h0802, "y new");
    end
    chk(y_ea_q, 16'h0800, "y ea");
  endtask

  task automatic t_atype();
    for (int i = 0; i < 6; i++)
    begin
      x_atype = oag_atype_t'(i % 3);
      x_prog_space = (i > 2);
      go(1'b1, 1'b0);
      chk(x_atype_q, (i == 5) ? OAG_LINEAR : x_atype, "atype");
      chk(x_prog_q, x_prog_space, "prog");
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  initial
  begin
    {srst, req, x_prog_space, file_op, move_op, mul, mul_pair, to_w, to_mem} = 9'h100;
    {y_req, y_mac, y_write, y_byte, ld_en, ld_idx, ld_val} = '0;
    {x_ptr_sel, base_sel, y_ptr_sel} = 12'h00a;
    {x_step, y_step, lit_ofs, move_addr} = {16'h2, 16'h2, 16'hfffe, 16'habcd};
    x_mode = OAG_IND;
    y_mode = OAG_IND;
    x_atype = OAG_LINEAR;
    {lit, file_addr} = {10'h3ff, 13'h1fff};
    {num_errors, num_checks, cycles} = '0;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    chk({x_valid_q, x_ptr_idx_q, y_ptr_idx_q}, 9'h0ff, "reset");
    ld(4'h3, 16'h0100);
    ld(4'h5, 16'h0020);
    ld(4'h0, 16'h0777);
    ld(4'ha, 16'h0800);
    t_offsets();
    t_modified();
    t_direct();
    t_file();
    t_y();
    t_atype();
    repeat (2) @(posedge clk);
    #1;
    chk(wregs[16*3 +: 16], 16'h00fe, "pointer kept");
    results();
  end
endmodule
`default_nettype wire
